// >>> pkg/msp_pkg.sv
package msp_pkg;
   // register map (word addresses on the plain port)
   localparam logic [3:0] MSP_ADDR_SETUP = 4'h0;
   localparam logic [3:0] MSP_ADDR_POL = 4'h1;
   localparam logic [3:0] MSP_ADDR_RESET = 4'h2;
   localparam logic [3:0] MSP_ADDR_STATUS = 4'h3;
   localparam logic [3:0] MSP_ADDR_IN_DATA = 4'h4;
   localparam logic [3:0] MSP_ADDR_OUT_DATA = 4'h5;
   // port setup register fields
   localparam int MSP_SETUP_IN_SERIAL = 0;
   localparam int MSP_SETUP_OUT_SERIAL = 1;
   localparam int MSP_SETUP_INREQ_POL = 2;
   localparam int MSP_SETUP_OVR_POL = 3;
   localparam int MSP_SETUP_OUT_VALID = 4;
   localparam int MSP_SETUP_OUT_CLOCK = 5;
   localparam int MSP_SETUP_IN_STROBE = 6;
   localparam logic [7:0] MSP_SETUP_RESET = 8'h00;
   // polarity register fields (1 = active high / rising edge)
   localparam int MSP_POL_ICLK = 0;
   localparam int MSP_POL_ISYNC = 1;
   localparam int MSP_POL_IERR = 2;
   localparam int MSP_POL_IVLD = 3;
   localparam int MSP_POL_OCLK = 4;
   localparam int MSP_POL_OSYNC = 5;
   localparam logic [7:0] MSP_POL_RESET = 8'h37;
   // reset register: full reset bit
   localparam int MSP_RESET_ALL = 0;
   // output data register: bit 8 marks packet start
   localparam int MSP_OUT_SYNC_BIT = 8;
   // status register fields
   localparam int MSP_ST_IN_AVAIL = 0;
   localparam int MSP_ST_IN_SYNC = 1;
   localparam int MSP_ST_IN_ERR = 2;
   localparam int MSP_ST_OUT_BUSY = 3;
   localparam int MSP_ST_IN_OVER = 4;
   // last serial bit index and output strobe half period minus one, in clock cycles
   localparam logic [2:0] MSP_LAST_BIT = 3'h7;
   localparam logic [1:0] MSP_STB_HALF = 2'h1;
endpackage

// >>> core/msp_stream_port.sv
module msp_stream_port
   import msp_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdData,
   input wire logic inStreamClock,
   input wire logic [7:0] inData,
   input wire logic inPacketSync,
   input wire logic inDataValid,
   output logic inRequest,
   output logic inRequestEn,
   output logic outStreamClock,
   output logic [7:0] outData,
   output logic outPacketSync,
   output logic outValidReady,
   input wire logic outRequest
);

   // ======================================================================
   // registers and full reset
   // ======================================================================
   logic [7:0] setup;
   logic [7:0] pol;
   logic softReset;
   logic [7:0] inByte;
   logic inByteSync;
   logic inByteErr;
   logic inAvail;
   logic inOver;
   logic [7:0] outByte;
   logic outByteSync;
   logic outPending;

   wire anyReset = rst | softReset;
   wire wrSetup = regWrite && regAddr == MSP_ADDR_SETUP;
   wire wrPol = regWrite && regAddr == MSP_ADDR_POL;
   wire wrReset = regWrite && regAddr == MSP_ADDR_RESET;
   wire wrOut = regWrite && regAddr == MSP_ADDR_OUT_DATA;
   wire rdIn = regRead && regAddr == MSP_ADDR_IN_DATA;

   // setup and polarity storage, restored by either reset
   always_ff @(posedge clock)
   begin
      if (anyReset)
      begin
         setup <= MSP_SETUP_RESET;
         pol <= MSP_POL_RESET;
      end
      else
      begin
         if (wrSetup) setup <= regWrData[7:0];
         if (wrPol) pol <= regWrData[7:0];
      end
   end

   // software full reset pulse lasts one cycle
   always_ff @(posedge clock)
   begin
      if (rst) softReset <= 1'b0;
      else softReset <= wrReset & regWrData[MSP_RESET_ALL];
   end

   // ======================================================================
   // input synchronisers
   // ======================================================================
   logic [11:0] inMeta;
   logic [11:0] inSync;
   always_ff @(posedge clock)
   begin
      inMeta <= {outRequest, inStreamClock, inDataValid, inPacketSync, inData};
      inSync <= inMeta;
   end
   wire [7:0] sData = inSync[7:0];
   wire sSync = inSync[8];
   wire sValid = inSync[9];
   wire sClk = inSync[10];
   wire sOutReq = inSync[11];
   logic sClkOld;
   always_ff @(posedge clock) sClkOld <= sClk;

   // ======================================================================
   // stream input
   // ======================================================================
   wire inSerial = setup[MSP_SETUP_IN_SERIAL];
   wire clkPolRise = pol[MSP_POL_ICLK];
   // active edge of the input clock or strobe
   wire inEdge = clkPolRise ? (sClk & ~sClkOld) : (~sClk & sClkOld);
   wire validAct = sValid == pol[MSP_POL_IVLD];
   wire syncAct = sSync == pol[MSP_POL_ISYNC];
   wire errAct = sData[1] == pol[MSP_POL_IERR];
   wire inTake = inEdge & validAct;
   logic [7:0] inShift;
   logic [2:0] inCount;
   logic inShiftSync;
   wire serialDone = inSerial && inCount == MSP_LAST_BIT;
   wire byteDone = inTake && (!inSerial || serialDone);

   // serial assembly: msb first, bit zero only
   always_ff @(posedge clock)
   begin
      if (anyReset)
      begin
         inShift <= 8'h00;
         inCount <= 3'h0;
         inShiftSync <= 1'b0;
      end
      else if (inTake && inSerial)
      begin
         inShift <= {inShift[6:0], sData[0]};
         inCount <= inCount + 3'h1;
         if (inCount == 3'h0) inShiftSync <= syncAct;
      end
      else if (inEdge && inSerial && syncAct && !validAct)
         inCount <= 3'h0;
   end

   // received byte holding register
   always_ff @(posedge clock)
   begin
      if (anyReset)
      begin
         inByte <= 8'h00;
         inByteSync <= 1'b0;
         inByteErr <= 1'b0;
         inAvail <= 1'b0;
         inOver <= 1'b0;
      end
      else
      begin
         if (byteDone)
         begin
            inByte <= inSerial ? {inShift[6:0], sData[0]} : sData;
            inByteSync <= inSerial ? inShiftSync : syncAct;
            inByteErr <= inSerial ? 1'b0 : errAct;
            inAvail <= 1'b1;
            if (inAvail && !rdIn) inOver <= 1'b1;
         end
         else if (rdIn)
            inAvail <= 1'b0;
      end
   end

   // request asks for a byte only while the holding register is empty
   wire reqActive = !inAvail;
   always_ff @(posedge clock)
   begin
      if (anyReset)
      begin
         inRequest <= 1'b1;
         inRequestEn <= 1'b0;
      end
      else
      begin
         inRequestEn <= !inSerial;
         inRequest <= reqActive ~^ setup[MSP_SETUP_INREQ_POL];
      end
   end

   // ======================================================================
   // stream output
   // ======================================================================
   typedef enum {MSP_IDLE, MSP_LOW, MSP_HIGH} msp_out_t;
   msp_out_t outState;
   logic [1:0] halfCnt;
   logic [2:0] bitCnt;
   logic [7:0] outShift;
   wire outSerial = setup[MSP_SETUP_OUT_SERIAL];
   wire useValid = setup[MSP_SETUP_OUT_VALID];
   wire ovrHigh = setup[MSP_SETUP_OVR_POL];
   wire oclkRise = pol[MSP_POL_OCLK];
   wire osyncHigh = pol[MSP_POL_OSYNC];
   // downstream request is active low
   wire reqSeen = !sOutReq;
   wire halfDone = halfCnt == MSP_STB_HALF;
   wire lastBit = !outSerial || bitCnt == MSP_LAST_BIT;
   wire startXfer = outState == MSP_IDLE && outPending && (useValid || reqSeen);

   // pending byte written by software
   always_ff @(posedge clock)
   begin
      if (anyReset)
      begin
         outByte <= 8'h00;
         outByteSync <= 1'b0;
         outPending <= 1'b0;
      end
      else if (wrOut && !outPending)
      begin
         outByte <= regWrData[7:0];
         outByteSync <= regWrData[MSP_OUT_SYNC_BIT];
         outPending <= 1'b1;
      end
      else if (startXfer)
         outPending <= 1'b0;
   end

   // strobe sequencer: low half drives data, high half makes active edge
   always_ff @(posedge clock)
   begin
      if (anyReset)
      begin
         outState <= MSP_IDLE;
         halfCnt <= 2'h0;
         bitCnt <= 3'h0;
         outShift <= 8'h00;
      end
      else
      begin
         case (outState)
            MSP_IDLE:
            begin
               halfCnt <= 2'h0;
               bitCnt <= 3'h0;
               if (startXfer)
               begin
                  outShift <= outByte;
                  outState <= MSP_LOW;
               end
            end
            MSP_LOW:
            begin
               halfCnt <= halfDone ? 2'h0 : halfCnt + 2'h1;
               if (halfDone) outState <= MSP_HIGH;
            end
            MSP_HIGH:
            begin
               halfCnt <= halfDone ? 2'h0 : halfCnt + 2'h1;
               if (halfDone)
               begin
                  bitCnt <= bitCnt + 3'h1;
                  outShift <= {outShift[6:0], 1'b0};
                  outState <= lastBit ? MSP_IDLE : MSP_LOW;
               end
            end
            default: outState <= MSP_IDLE;
         endcase
      end
   end

   // pin drivers, all registered
   wire busy = outState != MSP_IDLE;
   wire firstBit = bitCnt == 3'h0;
   wire [7:0] next_outData = outSerial ? {7'h00, outShift[7]} : outShift;
   wire strobeHigh = outState == MSP_HIGH;
   wire readyAct = useValid ? busy : (!outPending && !busy);
   logic syncLevel;
   logic outByteSyncLatched;
   assign syncLevel = busy && firstBit && outByteSyncLatched;
   always_ff @(posedge clock)
   begin
      if (anyReset) outByteSyncLatched <= 1'b0;
      else if (startXfer) outByteSyncLatched <= outByteSync;
   end
   always_ff @(posedge clock)
   begin
      if (anyReset)
      begin
         outStreamClock <= 1'b0;
         outData <= 8'h00;
         outPacketSync <= 1'b0;
         outValidReady <= 1'b1;
      end
      else
      begin
         outStreamClock <= strobeHigh ~^ oclkRise;
         outData <= busy ? next_outData : 8'h00;
         outPacketSync <= syncLevel ~^ osyncHigh;
         outValidReady <= readyAct ~^ ovrHigh;
      end
   end

   // ======================================================================
   // register read port
   // ======================================================================
   wire [15:0] statusWord = {11'h000, inOver, busy | outPending, inByteErr, inByteSync, inAvail};
   wire [15:0] readMux =
      regAddr == MSP_ADDR_SETUP ? {8'h00, setup} :
      regAddr == MSP_ADDR_POL ? {8'h00, pol} :
      regAddr == MSP_ADDR_STATUS ? statusWord :
      regAddr == MSP_ADDR_IN_DATA ? {8'h00, inByte} :
      regAddr == MSP_ADDR_OUT_DATA ? {7'h00, outByteSync, outByte} : 16'h0000;
   always_ff @(posedge clock)
   begin
      if (rst) regRdData <= 16'h0000;
      else regRdData <= regRead ? readMux : 16'h0000;
   end

   // ======================================================================
   // checks
   // ======================================================================
   sequence inByteSeq;
      byteDone ##1 inAvail;
   endsequence

   reqEnable_a: assert property (@(posedge clock) disable iff (rst)
      !anyReset |=> inRequestEn == !$past(inSerial)) else $error("request enable wrong");
   resetDefaults_a: assert property (@(posedge clock)
      $past(anyReset) |-> setup == MSP_SETUP_RESET && pol == MSP_POL_RESET)
      else $error("defaults not restored");
   inCapture_a: assert property (@(posedge clock) disable iff (anyReset)
      byteDone && !inSerial |=> inByte == $past(sData)) else $error("byte not captured");
   validGate_a: assert property (@(posedge clock) disable iff (anyReset)
      inEdge && !validAct |=> !$rose(inAvail)) else $error("byte taken while invalid");
   inSync_a: assert property (@(posedge clock) disable iff (anyReset)
      byteDone && !inSerial && syncAct |-> inByteSeq ##0 inByteSync) else $error("sync lost");
   outStart_a: assert property (@(posedge clock) disable iff (anyReset)
      outState == MSP_IDLE && outPending && !useValid && !reqSeen |=> outState == MSP_IDLE)
      else $error("sent without request");
   outStrobe_a: assert property (@(posedge clock) disable iff (anyReset)
      startXfer |=> outState == MSP_LOW [*2] ##1 outState == MSP_HIGH)
      else $error("strobe timing");
   serialOut_a: assert property (@(posedge clock) disable iff (anyReset)
      outSerial && busy && $stable(setup) |=> outData[7:1] == 7'h00)
      else $error("serial uses upper bits");
   // request, ready and strobe idle levels follow the setup and polarity registers
   reqLevel_a: assert property (@(posedge clock) disable iff (anyReset)
      !inAvail |=> inRequest == $past(setup[MSP_SETUP_INREQ_POL]))
      else $error("request level wrong");
   readyLevel_a: assert property (@(posedge clock) disable iff (anyReset)
      !useValid && !busy && !outPending |=> outValidReady == $past(ovrHigh))
      else $error("ready level wrong");
   strobeIdle_a: assert property (@(posedge clock) disable iff (anyReset)
      !busy |=> outStreamClock == !$past(oclkRise))
      else $error("strobe idle level wrong");
endmodule

// >>> sim/msp_stream_src.sv
// ==========================================
// stream source and sink beside the port pair
module msp_stream_src
(
   output logic inStreamClock,
   output logic [7:0] inData,
   output logic inPacketSync,
   output logic inDataValid,
   output logic outRequest,
   input wire logic outStreamClock,
   input wire logic [7:0] outData,
   input wire logic outPacketSync
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wantData = 1'b0;
   logic holdAfterFall = 1'b0;
   logic [7:0] rxLast = 8'h00;
   logic [7:0] rxShift = 8'h00;
   logic rxSync = 1'b0;
   int rxCount = 0;

   // link idles with clock still and valid inactive
   initial
   begin
      inStreamClock = 1'b0;
      inData = 8'hff;
      inPacketSync = 1'b0;
      inDataValid = 1'b1;
   end

   // request line low asks for data
   assign outRequest = ~wantData;

   // one unit per link clock period, sync beside the first unit
   task automatic sendUnit(input logic [7:0] d, input logic sync, input logic valid);
      inData = d;
      inPacketSync = sync;
      inDataValid = ~valid;
      #160 inStreamClock = 1'b1;
      #160 inStreamClock = 1'b0;
      if (holdAfterFall) #80; // falling-edge receivers need data past the edge
      inData = ~d; // released data and sync lines show the inverse
      inPacketSync = ~sync;
      inDataValid = 1'b1;
   endtask

   // capture output units on the rising strobe edge
   always @(posedge outStreamClock)
   begin
      rxLast = outData;
      rxShift = {rxShift[6:0], outData[0]};
      rxSync = outPacketSync;
      rxCount = rxCount + 1;
   end
endmodule

// >>> sim/mpeg_stream_port_pair_bench.sv
// ==========================================
// bench for the stream port pair
module mpeg_stream_port_pair_bench
   import msp_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [15:0] regWrData = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [15:0] regRdData, v;
   logic [7:0] inData, outData;
   logic inStreamClock, inPacketSync, inDataValid, inRequest, inRequestEn;
   logic outStreamClock, outPacketSync, outValidReady, outRequest;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;

   msp_stream_port i_dut (.clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .inStreamClock(inStreamClock), .inData(inData), .inPacketSync(inPacketSync),
      .inDataValid(inDataValid), .inRequest(inRequest), .inRequestEn(inRequestEn),
      .outStreamClock(outStreamClock), .outData(outData), .outPacketSync(outPacketSync),
      .outValidReady(outValidReady), .outRequest(outRequest));

   msp_stream_src i_src (.inStreamClock(inStreamClock), .inData(inData),
      .inPacketSync(inPacketSync), .inDataValid(inDataValid), .outRequest(outRequest),
      .outStreamClock(outStreamClock), .outData(outData), .outPacketSync(outPacketSync));

   // ==========================================
   // clock, timeout and shared tasks
   always #20 clock = ~clock;

   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 v = regRdData;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================
   // scenarios
   task automatic t_defaults();
      repeat (3) @(posedge clock);
      #1 chk("inRequest", 16'(inRequest), 16'h0000);
      chk("inRequestEn", 16'(inRequestEn), 16'h0001);
      chk("outStreamClock", 16'(outStreamClock), 16'h0000);
      chk("outValidReady", 16'(outValidReady), 16'h0000);
      chk("outPacketSync", 16'(outPacketSync), 16'h0000);
      rd(MSP_ADDR_SETUP);
      chk("setup", v, 16'h0000);
      rd(MSP_ADDR_POL);
      chk("polarity", v, 16'h0037);
      rd(4'hf);
      chk("unmapped", v, 16'h0000);
   endtask

   task automatic t_in_par();
      i_src.sendUnit(8'ha5, 1'b1, 1'b1);
      rd(MSP_ADDR_STATUS);
      chk("status a5", 16'(v[2:0]), 16'h0003);
      rd(MSP_ADDR_IN_DATA);
      chk("in byte a5", 16'(v[7:0]), 16'h00a5);
      i_src.sendUnit(8'h11, 1'b1, 1'b0);
      rd(MSP_ADDR_STATUS);
      chk("status no valid", 16'(v[0]), 16'h0000);
      i_src.sendUnit(8'h5a, 1'b0, 1'b1);
      #1 chk("inRequest held", 16'(inRequest), 16'h0001);
      rd(MSP_ADDR_STATUS);
      chk("status 5a", 16'(v[2:0]), 16'h0005);
      rd(MSP_ADDR_IN_DATA);
      chk("in byte 5a", 16'(v[7:0]), 16'h005a);
   endtask

   task automatic t_in_ser();
      wr(MSP_ADDR_SETUP, 16'h0001);
      repeat (2) @(posedge clock);
      #1 chk("inRequestEn serial", 16'(inRequestEn), 16'h0000);
      for (int i = 7; i >= 0; i--)
         i_src.sendUnit(8'(8'hc6 >> i), 1'(i == 7), 1'b1);
      rd(MSP_ADDR_IN_DATA);
      chk("serial in byte", 16'(v[7:0]), 16'h00c6);
   endtask

   task automatic t_out(input logic ser, input logic [7:0] d);
      int n;
      n = i_src.rxCount;
      wr(MSP_ADDR_SETUP, {14'h0000, ser, 1'b0});
      wr(MSP_ADDR_OUT_DATA, {7'h00, 1'b1, d});
      repeat (20) @(posedge clock);
      #1 chk("no request no send", 16'(i_src.rxCount - n), 16'h0000);
      chk("ready while pending", 16'(outValidReady), 16'h0001);
      i_src.wantData = 1'b1;
      for (int i = 0; i < 400 && i_src.rxCount < n + (ser ? 8 : 1); i++)
         @(posedge clock);
      chk("units sent", 16'(i_src.rxCount - n), ser ? 16'h0008 : 16'h0001);
      chk("out byte", 16'(ser ? i_src.rxShift : i_src.rxLast), 16'(d));
      if (!ser)
         chk("out sync", 16'(i_src.rxSync), 16'h0001);
      i_src.wantData = 1'b0;
   endtask

   task automatic t_out_valid();
      int n;
      wr(MSP_ADDR_SETUP, 16'h0010);
      n = i_src.rxCount;
      wr(MSP_ADDR_OUT_DATA, 16'h00e7);
      repeat (2) @(posedge clock);
      #1 chk("valid while sending", 16'(outValidReady), 16'h0000);
      for (int i = 0; i < 400 && i_src.rxCount < n + 1; i++)
         @(posedge clock);
      chk("valid mode unit", 16'(i_src.rxCount - n), 16'h0001);
      chk("valid mode byte", 16'(i_src.rxLast), 16'h00e7);
      chk("valid mode no sync", 16'(i_src.rxSync), 16'h0000);
      repeat (3) @(posedge clock);
      #1 chk("valid idle", 16'(outValidReady), 16'h0001);
   endtask

   task automatic t_in_pol();
      wr(MSP_ADDR_POL, 16'h0038);
      i_src.holdAfterFall = 1'b1;
      @(posedge clock);
      #1 i_src.sendUnit(8'h94, 1'b0, 1'b0);
      i_src.holdAfterFall = 1'b0;
      rd(MSP_ADDR_STATUS);
      chk("status inverted pol", 16'(v[2:0]), 16'h0007);
      rd(MSP_ADDR_IN_DATA);
      chk("byte on falling edge", 16'(v[7:0]), 16'h0094);
   endtask

   task automatic t_pol_reset();
      wr(MSP_ADDR_POL, 16'h0000);
      repeat (3) @(posedge clock);
      #1 chk("strobe idle falling", 16'(outStreamClock), 16'h0001);
      wr(MSP_ADDR_SETUP, 16'h0008);
      repeat (3) @(posedge clock);
      #1 chk("ready active high", 16'(outValidReady), 16'h0001);
      wr(MSP_ADDR_RESET, 16'h0001);
      repeat (3) @(posedge clock);
      rd(MSP_ADDR_SETUP);
      chk("setup after full reset", v, 16'h0000);
      rd(MSP_ADDR_POL);
      chk("pol after full reset", v, 16'h0037);
      chk("strobe after full reset", 16'(outStreamClock), 16'h0000);
   endtask

   // ==========================================
   // main sequence
   initial
   begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      t_defaults();
      t_in_par();
      t_in_ser();
      t_out(1'b0, 8'h3c);
      t_out(1'b1, 8'h81);
      t_out_valid();
      t_in_pol();
      t_pol_reset();
      tally_and_finish();
   end
endmodule
